// ===== hw/wwdt_fall_det.sv
/*
  Two-flop synchroniser with a falling-edge detector that demands a minimum low time.
  Assumes an asynchronous input and one core clock.
*/
`default_nettype none

module wwdt_fall_det #(
  parameter int MIN_LOW = 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Line
  input wire logic sig_i,
  output logic fall_o
);

  logic meta_ff;
  logic sync_ff;
  logic armed_ff;
  logic [7:0] low_cnt_ff;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else if (ce_i) begin
      meta_ff <= sig_i;
      sync_ff <= meta_ff;
    end
  end

  // Synchroniser flops reset high, so a line already low at reset still arms and is taken as an edge
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_ff <= 1'b0;
      low_cnt_ff <= 8'h00;
    end else if (ce_i) begin
      if (sync_ff) begin
        armed_ff <= 1'b1;
        low_cnt_ff <= 8'h00;
      end else if (low_cnt_ff != 8'(MIN_LOW)) begin
        low_cnt_ff <= low_cnt_ff + 8'h01;
      end
    end
  end

  assign fall_o = ce_i & armed_ff & ~sync_ff & (low_cnt_ff == 8'(MIN_LOW - 1));

endmodule // wwdt_fall_det

`default_nettype wire

// ===== hw/wwdt_pkg.sv
/*
  Constants, types and timing counts of the window watchdog.
  Assumes a 20 MHz core clock and an oscillator tick from the analog timing cell.
*/
`default_nettype none

package wwdt_pkg;

  localparam int WWDT_CLK_PERIOD_NS = 50;
  localparam int WWDT_TRIG_MIN_NS = 200;
  localparam int WWDT_TRIG_MIN_CYC =
    (WWDT_TRIG_MIN_NS + WWDT_CLK_PERIOD_NS - 1) / WWDT_CLK_PERIOD_NS;
  localparam int WWDT_NRES_US = 4000;
  localparam int WWDT_NRES_CYC = WWDT_NRES_US * 1000 / WWDT_CLK_PERIOD_NS;

  localparam int WWDT_LEAD_OSC = 7895;
  localparam int WWDT_CLOSED_OSC = 1053;
  localparam int WWDT_OPEN_OSC = 1105;

  // Documented resistor and trigger-period span, kept for reference by software models
  localparam int WWDT_RES_MIN_KOHM = 34;
  localparam int WWDT_RES_MAX_KOHM = 120;
  localparam int WWDT_PERIOD_MIN_MS = 20;
  localparam int WWDT_PERIOD_MAX_MS = 64;

  // Fallback oscillator divider, about 19.6 us at 20 MHz
  localparam int WWDT_FB_DIV = 392;
  localparam int WWDT_FB_W = 9;
  localparam int WWDT_CNT_W = 17;

  typedef enum logic [2:0] {
    WWDT_PWRUP,
    WWDT_LEAD,
    WWDT_CLOSED,
    WWDT_OPEN,
    WWDT_RESET,
    WWDT_STOP
  } wwdt_state_t;

  typedef struct packed {
    logic low_power;
    logic uv_reset;
    logic res_fault;
  } wwdt_ctl_t;

endpackage

`default_nettype wire

// ===== hw/wwdt_top.sv
/*
  Window watchdog: lead time, closed and open windows, reset pulse to the host.
  Assumes osc_tick_i is a one-cycle pulse per oscillator period, synchronous to core_clk_i.
*/
`default_nettype none

module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int RST_CYC = WWDT_NRES_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Timing and chip control
  input wire logic osc_tick_i,
  input wire wwdt_ctl_t ctl_i,
  input wire logic rx_data_i,
  // Host trigger
  input wire logic wd_trigger_n,
  // Reset pin, open drain
  input wire logic nres_pin_i,
  output logic nres_o,
  output logic nres_oe_o,
  // Status
  output logic failsafe_o,
  output wwdt_state_t phase_o
);

  wwdt_state_t state_ff;
  wwdt_state_t nxt_state;
  logic [WWDT_CNT_W-1:0] cnt_ff;
  logic [WWDT_CNT_W-1:0] nxt_cnt;
  logic [WWDT_FB_W-1:0] fb_div_ff;
  logic [1:0] fb_trig_ff;
  logic nres_oe_ff;
  logic fb_tick;
  logic tick;
  logic trig;
  logic rx_fall;
  logic fb_kill;
  logic cnt_last;

  wwdt_fall_det #(
    .MIN_LOW(WWDT_TRIG_MIN_CYC)
  ) u_trig (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sig_i(wd_trigger_n),
    .fall_o(trig)
  );

  wwdt_fall_det #(
    .MIN_LOW(1)
  ) u_wake (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sig_i(rx_data_i),
    .fall_o(rx_fall)
  );

  // Fallback timebase only matters when the resistor is missing or shorted
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fb_div_ff <= 9'h000;
    end else if (ce_i) begin
      if (fb_div_ff == WWDT_FB_W'(WWDT_FB_DIV - 1)) begin
        fb_div_ff <= 9'h000;
      end else begin
        fb_div_ff <= fb_div_ff + 9'h001;
      end
    end
  end

  assign fb_tick = (fb_div_ff == WWDT_FB_W'(WWDT_FB_DIV - 1));
  assign tick = ctl_i.res_fault ? fb_tick : osc_tick_i;

  // Without a trusted timebase the window check is meaningless, so force a reset at trigger two
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fb_trig_ff <= 2'h0;
    end else if (ce_i) begin
      if (!ctl_i.res_fault || state_ff == WWDT_RESET) begin
        fb_trig_ff <= 2'h0;
      end else if (trig && fb_trig_ff != 2'h2) begin
        fb_trig_ff <= fb_trig_ff + 2'h1;
      end
    end
  end

  assign fb_kill = ctl_i.res_fault & trig & (fb_trig_ff == 2'h1);

  always_comb begin
    case (state_ff)
      WWDT_PWRUP: cnt_last = (cnt_ff == WWDT_CNT_W'(RST_CYC - 1));
      WWDT_RESET: cnt_last = (cnt_ff == WWDT_CNT_W'(RST_CYC - 1));
      WWDT_LEAD: cnt_last = tick & (cnt_ff == WWDT_CNT_W'(WWDT_LEAD_OSC - 1));
      WWDT_CLOSED: cnt_last = tick & (cnt_ff == WWDT_CNT_W'(WWDT_CLOSED_OSC - 1));
      WWDT_OPEN: cnt_last = tick & (cnt_ff == WWDT_CNT_W'(WWDT_OPEN_OSC - 1));
      default: cnt_last = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      WWDT_PWRUP: begin
        nxt_cnt = cnt_ff + 17'h0_0001;
        if (cnt_last) begin
          nxt_state = WWDT_LEAD;
          nxt_cnt = 17'h0_0000;
        end
      end
      WWDT_LEAD: begin
        if (trig && !fb_kill) begin
          nxt_state = WWDT_CLOSED;
          nxt_cnt = 17'h0_0000;
        end else if (trig || cnt_last) begin
          nxt_state = WWDT_RESET;
          nxt_cnt = 17'h0_0000;
        end else if (tick) begin
          nxt_cnt = cnt_ff + 17'h0_0001;
        end
      end
      WWDT_CLOSED: begin
        if (trig) begin
          nxt_state = WWDT_RESET;
          nxt_cnt = 17'h0_0000;
        end else if (cnt_last) begin
          nxt_state = WWDT_OPEN;
          nxt_cnt = 17'h0_0000;
        end else if (tick) begin
          nxt_cnt = cnt_ff + 17'h0_0001;
        end
      end
      WWDT_OPEN: begin
        if (trig && !fb_kill) begin
          nxt_state = WWDT_CLOSED;
          nxt_cnt = 17'h0_0000;
        end else if (trig || cnt_last) begin
          nxt_state = WWDT_RESET;
          nxt_cnt = 17'h0_0000;
        end else if (tick) begin
          nxt_cnt = cnt_ff + 17'h0_0001;
        end
      end
      WWDT_RESET: begin
        nxt_cnt = cnt_ff + 17'h0_0001;
        if (cnt_last) begin
          nxt_state = WWDT_LEAD;
          nxt_cnt = 17'h0_0000;
        end
      end
      WWDT_STOP: begin
        if (rx_fall) begin
          nxt_state = WWDT_LEAD;
          nxt_cnt = 17'h0_0000;
        end
      end
      default: begin
        nxt_state = WWDT_PWRUP;
        nxt_cnt = 17'h0_0000;
      end
    endcase
    // Low power wins over any window event; wake edge is only looked at once stopped
    if (ctl_i.low_power && state_ff != WWDT_STOP && state_ff != WWDT_PWRUP) begin
      nxt_state = WWDT_STOP;
      nxt_cnt = 17'h0_0000;
    end
    if (ctl_i.uv_reset) begin
      nxt_state = WWDT_PWRUP;
      nxt_cnt = 17'h0_0000;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= WWDT_PWRUP;
      cnt_ff <= 17'h0_0000;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nres_oe_ff <= 1'b1;
    end else if (ce_i) begin
      nres_oe_ff <= (nxt_state == WWDT_PWRUP) || (nxt_state == WWDT_RESET);
    end
  end

  assign nres_o = 1'b0;
  assign nres_oe_o = nres_oe_ff;
  assign failsafe_o = ~nres_pin_i;
  assign phase_o = state_ff;

  property p_closed_trig;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_CLOSED && trig && !ctl_i.low_power && !ctl_i.uv_reset
    |=> state_ff == WWDT_RESET && nres_oe_o;
  endproperty
  a_closed_trig: assert property (p_closed_trig) else $error("early trigger no reset");

  property p_open_trig;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_OPEN && trig && !fb_kill && !ctl_i.low_power && !ctl_i.uv_reset
    |=> state_ff == WWDT_CLOSED && cnt_ff == 17'h0_0000 && !nres_oe_o;
  endproperty
  a_open_trig: assert property (p_open_trig) else $error("open trigger no restart");

  property p_lead_trig;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_LEAD && trig && !fb_kill && !ctl_i.low_power && !ctl_i.uv_reset
    |=> state_ff == WWDT_CLOSED;
  endproperty
  a_lead_trig: assert property (p_lead_trig) else $error("lead trigger ignored");

  property p_lead_expire;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_LEAD && tick && !trig && !ctl_i.low_power && !ctl_i.uv_reset
    && cnt_ff == 17'h0_1ED6
    |=> state_ff == WWDT_RESET && nres_oe_o;
  endproperty
  a_lead_expire: assert property (p_lead_expire) else $error("lead expiry no reset");

  property p_open_expire;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_OPEN && tick && !trig && !ctl_i.low_power && !ctl_i.uv_reset
    && cnt_ff == 17'h0_0450
    |=> state_ff == WWDT_RESET;
  endproperty
  a_open_expire: assert property (p_open_expire) else $error("open expiry no reset");

  property p_closed_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_CLOSED && !(tick && cnt_ff == 17'h0_041C) && !trig
    && !ctl_i.low_power && !ctl_i.uv_reset
    |=> state_ff == WWDT_CLOSED && !nres_oe_o;
  endproperty
  a_closed_hold: assert property (p_closed_hold) else $error("closed window cut");

  property p_to_open;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_CLOSED && tick && cnt_ff == 17'h0_041C && !trig
    && !ctl_i.low_power && !ctl_i.uv_reset
    |=> state_ff == WWDT_OPEN && cnt_ff == 17'h0_0000 && !nres_oe_o;
  endproperty
  a_to_open: assert property (p_to_open) else $error("closed window overran");

  property p_stop;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && ctl_i.low_power && !ctl_i.uv_reset && state_ff != WWDT_PWRUP
    |=> state_ff == WWDT_STOP && !nres_oe_o;
  endproperty
  a_stop: assert property (p_stop) else $error("low power did not stop watchdog");

  property p_rst_end;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_RESET && cnt_last && !ctl_i.low_power && !ctl_i.uv_reset
    |=> state_ff == WWDT_LEAD && cnt_ff == 17'h0_0000 && !nres_oe_o;
  endproperty
  a_rst_end: assert property (p_rst_end) else $error("reset pulse not followed by lead");

  property p_uv;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && ctl_i.uv_reset |=> state_ff == WWDT_PWRUP && nres_oe_o;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage did not restart");

  property p_nres_map;
    @(posedge core_clk_i) disable iff (rst_i)
    nres_oe_o == (state_ff == WWDT_PWRUP || state_ff == WWDT_RESET);
  endproperty
  a_nres_map: assert property (p_nres_map) else $error("reset pin off its phase");

  property p_open_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_OPEN && !(tick && cnt_ff == 17'h0_0450) && !trig
    && !ctl_i.low_power && !ctl_i.uv_reset
    |=> state_ff == WWDT_OPEN && !nres_oe_o;
  endproperty
  a_open_hold: assert property (p_open_hold) else $error("open window cut");

  property p_cnt_tick;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && (state_ff == WWDT_LEAD || state_ff == WWDT_CLOSED || state_ff == WWDT_OPEN)
    && !tick && !trig && !ctl_i.low_power && !ctl_i.uv_reset
    |=> $stable(cnt_ff) && $stable(state_ff);
  endproperty
  a_cnt_tick: assert property (p_cnt_tick) else $error("window moved without tick");

  property p_pwrup_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_PWRUP && !cnt_last
    |=> state_ff == WWDT_PWRUP && nres_oe_o;
  endproperty
  a_pwrup_hold: assert property (p_pwrup_hold) else $error("power-up pulse short");

  property p_pwrup_end;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_PWRUP && cnt_last && !ctl_i.uv_reset
    |=> state_ff == WWDT_LEAD && cnt_ff == 17'h0_0000 && !nres_oe_o;
  endproperty
  a_pwrup_end: assert property (p_pwrup_end) else $error("no lead after power-up");

  property p_rst_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_RESET && !cnt_last && !ctl_i.low_power && !ctl_i.uv_reset
    |=> state_ff == WWDT_RESET && nres_oe_o;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset pulse cut short");

  property p_stop_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_STOP && !rx_fall && !ctl_i.uv_reset
    |=> state_ff == WWDT_STOP && !nres_oe_o;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped watchdog moved");

  property p_wake;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && state_ff == WWDT_STOP && rx_fall && !ctl_i.uv_reset
    |=> state_ff == WWDT_LEAD && cnt_ff == 17'h0_0000;
  endproperty
  a_wake: assert property (p_wake) else $error("wake edge did not start lead");

  property p_fb_kill;
    @(posedge core_clk_i) disable iff (rst_i)
    ce_i && ctl_i.res_fault && trig && fb_trig_ff == 2'h1
    && (state_ff == WWDT_LEAD || state_ff == WWDT_OPEN)
    && !ctl_i.low_power && !ctl_i.uv_reset
    |=> state_ff == WWDT_RESET && nres_oe_o;
  endproperty
  a_fb_kill: assert property (p_fb_kill) else $error("fallback trigger no reset");

  property p_freeze;
    @(posedge core_clk_i) disable iff (rst_i)
    !ce_i |=> $stable(state_ff) && $stable(cnt_ff) && $stable(nres_oe_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

endmodule // wwdt_top

`default_nettype wire

// ===== sim/wwdt_host_model.sv
/*
  Host side model: drives the active-low watchdog trigger line.
  Assumes the bench calls pulse just after a falling clock edge.
*/
`default_nettype none

module wwdt_host_model (
  // Clock and reset pin
  input wire logic core_clk_i,
  input wire logic nres_pin_i,
  // Trigger
  output logic wd_trigger_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial wd_trigger_n = 1'b1;

  // A host held in reset cannot trigger, so a request then is dropped
  task automatic pulse(input int n);
    if (nres_pin_i) begin
      wd_trigger_n = 1'b0;
      repeat (n) @(negedge core_clk_i);
      wd_trigger_n = 1'b1;
    end
  endtask
endmodule // wwdt_host_model

`default_nettype wire

// ===== sim/wwdt_top_bench.sv
/*
  Self-checking bench of the window watchdog with a host model on the trigger.
  Assumes an oscillator tick every second clock and a pulled-up reset pin.
*/
`default_nettype none

module wwdt_top_bench;
  import wwdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // Short reset pulse keeps the run small
  localparam int RST_CYC = 20;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic osc_tick_i = 1'b0;
  logic rx_data_i = 1'b1;
  wwdt_ctl_t ctl_i = '0;
  logic wd_trigger_n;
  logic nres_o;
  logic nres_oe_o;
  logic failsafe_o;
  logic nres_pin_i;
  wwdt_state_t phase_o;
  int err_total = 0;
  int total_checks = 0;
  int n;

  // Open-drain pin with pull-up
  assign nres_pin_i = nres_oe_o ? nres_o : 1'b1;

  initial forever #25 core_clk_i = ~core_clk_i;

  always @(negedge core_clk_i) osc_tick_i <= ~osc_tick_i;

  wwdt_top #(.RST_CYC(RST_CYC)) dut_u (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .osc_tick_i(osc_tick_i),
    .ctl_i(ctl_i),
    .rx_data_i(rx_data_i),
    .wd_trigger_n(wd_trigger_n),
    .nres_pin_i(nres_pin_i),
    .nres_o(nres_o),
    .nres_oe_o(nres_oe_o),
    .failsafe_o(failsafe_o),
    .phase_o(phase_o)
  );

  wwdt_host_model host_u (
    .core_clk_i(core_clk_i),
    .nres_pin_i(nres_pin_i),
    .wd_trigger_n(wd_trigger_n)
  );

  task automatic conclude();
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Clock counts carry a small margin for tick phase and sync delay
  function automatic logic near(input int v, input int e);
    return v >= e - 4 && v <= e + 4;
  endfunction

  task automatic wait_ph(input wwdt_state_t s, input int bound, output int cnt);
    cnt = 0;
    while (phase_o !== s) begin
      @(negedge core_clk_i);
      cnt++;
      if (cnt > bound) begin
        err_total++;
        $display("CHECK FAILED wait phase expected %0d seen timeout", s);
        conclude();
      end
    end
  endtask

  // Phase answers five clocks after the first low sample
  task automatic trig(input int len);
    host_u.pulse(len);
    repeat (4) @(negedge core_clk_i);
  endtask

  task automatic t_powerup();
    check("pwrup phase", phase_o, WWDT_PWRUP);
    check("pwrup oe", nres_oe_o, 1'b1);
    check("pin data", nres_o, 1'b0);
    check("pwrup failsafe", failsafe_o, 1'b1);
    wait_ph(WWDT_LEAD, 40, n);
    check("pwrup len", near(n, RST_CYC), 1'b1);
    check("lead oe", nres_oe_o, 1'b0);
    check("lead failsafe", failsafe_o, 1'b0);
  endtask

  task automatic t_lead_trig();
    trig(3);
    check("glitch", phase_o, WWDT_LEAD);
    trig(4);
    check("lead trig", phase_o, WWDT_CLOSED);
  endtask

  task automatic t_windows();
    wait_ph(WWDT_OPEN, 3000, n);
    check("closed len", near(n, 2 * WWDT_CLOSED_OSC), 1'b1);
    trig(4);
    check("open trig", phase_o, WWDT_CLOSED);
    trig(4);
    check("early trig", phase_o, WWDT_RESET);
    check("early oe", nres_oe_o, 1'b1);
    wait_ph(WWDT_LEAD, 40, n);
    check("reset len", near(n, RST_CYC), 1'b1);
  endtask

  task automatic t_lead_exp();
    wait_ph(WWDT_RESET, 17000, n);
    check("lead len", near(n, 2 * WWDT_LEAD_OSC), 1'b1);
    check("lead exp oe", nres_oe_o, 1'b1);
    wait_ph(WWDT_LEAD, 40, n);
  endtask

  task automatic t_open_exp();
    trig(4);
    wait_ph(WWDT_OPEN, 3000, n);
    wait_ph(WWDT_RESET, 3000, n);
    check("open len", near(n, 2 * WWDT_OPEN_OSC), 1'b1);
    check("open exp oe", nres_oe_o, 1'b1);
    wait_ph(WWDT_LEAD, 40, n);
  endtask

  // Stop is held past a whole lead time to show nothing counts
  task automatic t_low_power();
    ctl_i.low_power = 1'b1;
    repeat (2) @(negedge core_clk_i);
    check("stop", phase_o, WWDT_STOP);
    repeat (16000) @(negedge core_clk_i);
    check("stop held", phase_o, WWDT_STOP);
    check("stop oe", nres_oe_o, 1'b0);
    ctl_i.low_power = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check("no wake", phase_o, WWDT_STOP);
    rx_data_i = 1'b0;
    wait_ph(WWDT_LEAD, 6, n);
    check("wake", phase_o, WWDT_LEAD);
    rx_data_i = 1'b1;
  endtask

  task automatic t_uv();
    ctl_i.uv_reset = 1'b1;
    repeat (2) @(negedge core_clk_i);
    check("uv phase", phase_o, WWDT_PWRUP);
    check("uv oe", nres_oe_o, 1'b1);
    ctl_i.uv_reset = 1'b0;
    wait_ph(WWDT_LEAD, 40, n);
    check("uv len", near(n, RST_CYC), 1'b1);
  endtask

  // Undervoltage keeps the fallback trigger count, so the next trigger is the second
  task automatic t_fallback();
    ctl_i.res_fault = 1'b1;
    trig(4);
    check("fb first", phase_o, WWDT_CLOSED);
    ctl_i.uv_reset = 1'b1;
    @(negedge core_clk_i);
    ctl_i.uv_reset = 1'b0;
    wait_ph(WWDT_LEAD, 40, n);
    trig(4);
    check("fb second", phase_o, WWDT_RESET);
    check("fb oe", nres_oe_o, 1'b1);
    ce_i = 1'b0;
    repeat (40) @(negedge core_clk_i);
    check("freeze phase", phase_o, WWDT_RESET);
    check("freeze oe", nres_oe_o, 1'b1);
    ce_i = 1'b1;
    wait_ph(WWDT_LEAD, 40, n);
    check("freeze len", near(n, RST_CYC - 2), 1'b1);
    ctl_i.res_fault = 1'b0;
  endtask

  initial begin
    repeat (10) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_powerup();
    t_lead_trig();
    t_windows();
    t_lead_exp();
    t_open_exp();
    t_low_power();
    t_uv();
    t_fallback();
    conclude();
  end
endmodule // wwdt_top_bench

`default_nettype wire
